// ==== core/lcs_regs.sv ====
// LED current setting register bank with serial target and current select
//
// Functional notes
// - Low battery code, bits 5:0, reset 0x10
// - Channel 1 flash code, reset 0x28
// - Channel 1 mask code, reset 0x28
// - Channel 1 torch code, 5 bits, reset 0x04
// - Channel 2 flash code, reset 0x28
// - Channel 2 mask code, reset 0x28
// - Channel 2 torch code, 5 bits, reset 0x04
// - Six-bit current is code times 18.7mA, saturating
// - Torch current steps 18.7mA, saturating at 299.2mA
// - Three-bit output mode decode
// - Multipurpose pin configured by two-bit field
// - Low battery code only when threshold nonzero
`default_nettype none
module lcs_regs
	import lcs_pkg::*;
#(
	parameter int unsigned DEGLITCH_CYC = LCS_DEGLITCH_CYC
)(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// Serial link, open drain data
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out_r,
	output logic sda_oe_r,
	// Configuration from neighbouring registers
	input wire logic [2:0] output_mode_field,
	input wire logic [1:0] pin_cfg_field,
	input wire logic [2:0] low_batt_threshold_field,
	// Pins and analog status
	input wire logic multipurpose_pin_in,
	input wire logic low_batt_detect_in,
	// Current source control
	output logic [5:0] ch1_code_r,
	output logic [5:0] ch2_code_r,
	output logic [13:0] ch1_current_r,
	output logic [13:0] ch2_current_r,
	output logic mask_applied_r,
	output logic low_batt_applied_r
);
	// ----------------------------------------------------------------
	// Link edge and condition detect
	// ----------------------------------------------------------------
	logic scl_q_r;
	logic sda_q_r;
	wire scl_rise = scl_in & ~scl_q_r;
	wire scl_fall = ~scl_in & scl_q_r;
	wire start_c = scl_in & scl_q_r & sda_q_r & ~sda_in;
	wire stop_c = scl_in & scl_q_r & ~sda_q_r & sda_in;

	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			scl_q_r <= 1'b1;
			sda_q_r <= 1'b1;
		end
		else
		begin
			scl_q_r <= scl_in;
			sda_q_r <= sda_in;
		end
	end

	// ----------------------------------------------------------------
	// Register storage
	// ----------------------------------------------------------------
	logic [5:0] code_r [LCS_NUM_REGS];
	logic [7:0] ptr_r;
	logic [7:0] shift_r;
	wire [7:0] ptr_rel = ptr_r - LCS_OFS_LOW_BATT;
	wire ptr_mapped = (ptr_r >= LCS_OFS_LOW_BATT) && (ptr_r <= LCS_OFS_CH2_TORCH);
	wire [2:0] reg_idx = ptr_rel[2:0];
	wire [7:0] rd_byte = ptr_mapped ? {2'b00, code_r[reg_idx]} : 8'h00;
	logic wr_fire;

	genvar g;
	generate
		for (g = 0; g < LCS_NUM_REGS; g++)
		begin : g_reg
			always_ff @(posedge clk_sys)
			begin
				if (srst)
					code_r[g] <= LCS_RST[g];
				else if (wr_fire && reg_idx == 3'(g))
					code_r[g] <= shift_r[5:0] & LCS_MASK[g];
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Serial target state machine
	// ----------------------------------------------------------------
	lcs_state_t state_r;
	lcs_state_t state_nxt;
	logic [3:0] bit_cnt_r;
	logic [3:0] bit_cnt_nxt;
	logic ack_phase_r;
	logic ack_phase_nxt;
	logic nack_r;
	logic nack_nxt;
	logic read_dir_r;
	logic read_dir_nxt;
	logic sda_oe_nxt;
	logic [7:0] shift_nxt;
	logic [7:0] ptr_nxt;

	wire byte_done = scl_fall && !ack_phase_r && bit_cnt_r == 4'h8;
	wire rx_state = state_r == ST_ADDR || state_r == ST_PTR || state_r == ST_WR;
	assign wr_fire = state_r == ST_WR && byte_done && ptr_mapped;

	always_comb
	begin
		state_nxt = state_r;
		bit_cnt_nxt = bit_cnt_r;
		ack_phase_nxt = ack_phase_r;
		nack_nxt = nack_r;
		read_dir_nxt = read_dir_r;
		sda_oe_nxt = sda_oe_r;
		shift_nxt = shift_r;
		ptr_nxt = ptr_r;
		if (start_c)
		begin
			state_nxt = ST_ADDR;
			bit_cnt_nxt = 4'h0;
			ack_phase_nxt = 1'b0;
			sda_oe_nxt = 1'b0;
		end
		else if (stop_c)
		begin
			state_nxt = ST_IDLE;
			sda_oe_nxt = 1'b0;
		end
		else if (rx_state && scl_rise && !ack_phase_r && bit_cnt_r != 4'h8)
		begin
			shift_nxt = {shift_r[6:0], sda_in};
			bit_cnt_nxt = bit_cnt_r + 4'h1;
		end
		else if (rx_state && byte_done)
		begin
			ack_phase_nxt = 1'b1;
			sda_oe_nxt = 1'b1;
			bit_cnt_nxt = 4'h0;
			unique case (state_r)
				ST_ADDR:
				begin
					read_dir_nxt = shift_r[0];
					if (shift_r[7:1] != LCS_DEV_ADDR)
					begin
						state_nxt = ST_IDLE;
						ack_phase_nxt = 1'b0;
						sda_oe_nxt = 1'b0;
					end
				end
				ST_PTR: ptr_nxt = shift_r;
				default: ptr_nxt = ptr_r + 8'h01;
			endcase
		end
		else if (rx_state && scl_fall && ack_phase_r)
		begin
			ack_phase_nxt = 1'b0;
			sda_oe_nxt = 1'b0;
			unique case (state_r)
				ST_ADDR:
				begin
					if (read_dir_r)
					begin
						state_nxt = ST_RD;
						shift_nxt = rd_byte;
						sda_oe_nxt = ~rd_byte[7];
						ptr_nxt = ptr_r + 8'h01;
					end
					else
						state_nxt = ST_PTR;
				end
				default: state_nxt = ST_WR;
			endcase
		end
		else if (state_r == ST_RD && scl_fall)
		begin
			if (bit_cnt_r == 4'h7)
			begin
				state_nxt = ST_RACK;
				sda_oe_nxt = 1'b0;
				bit_cnt_nxt = 4'h0;
			end
			else
			begin
				shift_nxt = {shift_r[6:0], 1'b0};
				sda_oe_nxt = ~shift_r[6];
				bit_cnt_nxt = bit_cnt_r + 4'h1;
			end
		end
		else if (state_r == ST_RACK && scl_rise)
			nack_nxt = sda_in;
		else if (state_r == ST_RACK && scl_fall)
		begin
			if (nack_r)
				state_nxt = ST_IDLE;
			else
			begin
				state_nxt = ST_RD;
				shift_nxt = rd_byte;
				sda_oe_nxt = ~rd_byte[7];
				ptr_nxt = ptr_r + 8'h01;
			end
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			state_r <= ST_IDLE;
			bit_cnt_r <= 4'h0;
			ack_phase_r <= 1'b0;
			nack_r <= 1'b0;
			read_dir_r <= 1'b0;
			sda_oe_r <= 1'b0;
			sda_out_r <= 1'b0;
			shift_r <= 8'h00;
			ptr_r <= 8'h00;
		end
		else
		begin
			state_r <= state_nxt;
			bit_cnt_r <= bit_cnt_nxt;
			ack_phase_r <= ack_phase_nxt;
			nack_r <= nack_nxt;
			read_dir_r <= read_dir_nxt;
			sda_oe_r <= sda_oe_nxt;
			sda_out_r <= 1'b0;
			shift_r <= shift_nxt;
			ptr_r <= ptr_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Multipurpose pin and torch deglitch
	// ----------------------------------------------------------------
	logic [19:0] dg_cnt_r;
	logic torch_filt_r;
	wire dg_differs = multipurpose_pin_in != torch_filt_r;
	wire dg_done = dg_cnt_r == 20'(DEGLITCH_CYC - 1);
	wire transmitter_mask_input = (pin_cfg_field == LCS_PIN_MASK) & multipurpose_pin_in;
	wire torch_act = ((pin_cfg_field == LCS_PIN_TORCH) & torch_filt_r)
		| ((pin_cfg_field == LCS_PIN_TORCH_RAW) & multipurpose_pin_in);
	wire low_batt_act = (low_batt_threshold_field != LCS_LB_OFF) & low_batt_detect_in;

	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			dg_cnt_r <= 20'h0_0000;
			torch_filt_r <= 1'b0;
		end
		else if (!dg_differs)
			dg_cnt_r <= 20'h0_0000;
		else if (dg_done)
		begin
			dg_cnt_r <= 20'h0_0000;
			torch_filt_r <= multipurpose_pin_in;
		end
		else
			dg_cnt_r <= dg_cnt_r + 20'h0_0001;
	end

	// ----------------------------------------------------------------
	// Mode decode and per channel code select
	// ----------------------------------------------------------------
	wire mode_flash = output_mode_field == LCS_MODE_FLASH
		|| output_mode_field == LCS_MODE_IND_TO
		|| output_mode_field == LCS_MODE_IND_NTO;
	wire mode_torch = output_mode_field == LCS_MODE_ASSIST
		|| output_mode_field == LCS_MODE_FIX_TORCH
		|| (output_mode_field == LCS_MODE_STANDBY && torch_act);
	logic [5:0] sel_code [LCS_NUM_CH];
	logic [13:0] sel_cur [LCS_NUM_CH];

	generate
		for (g = 0; g < LCS_NUM_CH; g++)
		begin : g_ch
			localparam int FI = LCS_CH_BASE_IDX + g * LCS_CH_STRIDE;
			wire [5:0] fl_code = transmitter_mask_input ? code_r[FI + 1]
				: low_batt_act ? code_r[0] : code_r[FI];
			wire [4:0] tq_code = code_r[FI + 2][4:0];
			wire [5:0] fl_sat = (fl_code > LCS_FLASH_SAT) ? LCS_FLASH_SAT : fl_code;
			wire [4:0] tq_sat = (tq_code > LCS_TORCH_SAT) ? LCS_TORCH_SAT : tq_code;
			wire [13:0] fl_cur = 14'(fl_sat * LCS_STEP_DMA);
			wire [13:0] tq_cur = 14'(tq_sat * LCS_STEP_DMA);
			assign sel_code[g] = mode_flash ? fl_code : mode_torch ? {1'b0, tq_code} : 6'h00;
			assign sel_cur[g] = mode_flash ? fl_cur : mode_torch ? tq_cur : 14'h0000;
		end
	endgenerate

	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			ch1_code_r <= 6'h00;
			ch2_code_r <= 6'h00;
			ch1_current_r <= 14'h0000;
			ch2_current_r <= 14'h0000;
			mask_applied_r <= 1'b0;
			low_batt_applied_r <= 1'b0;
		end
		else
		begin
			ch1_code_r <= sel_code[0];
			ch2_code_r <= sel_code[1];
			ch1_current_r <= sel_cur[0];
			ch2_current_r <= sel_cur[1];
			mask_applied_r <= mode_flash & transmitter_mask_input;
			low_batt_applied_r <= mode_flash & ~transmitter_mask_input & low_batt_act;
		end
	end

endmodule // lcs_regs
`default_nettype wire

// ==== core/lcs_pkg.sv ====
// Constants for the LED current setting register bank
`default_nettype none
package lcs_pkg;
	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] LCS_OFS_LOW_BATT = 8'h05;
	localparam logic [7:0] LCS_OFS_CH1_FLASH = 8'h06;
	localparam logic [7:0] LCS_OFS_CH1_MASK = 8'h07;
	localparam logic [7:0] LCS_OFS_CH1_TORCH = 8'h08;
	localparam logic [7:0] LCS_OFS_CH2_FLASH = 8'h09;
	localparam logic [7:0] LCS_OFS_CH2_MASK = 8'h0a;
	localparam logic [7:0] LCS_OFS_CH2_TORCH = 8'h0b;
	localparam int LCS_NUM_REGS = 7;
	localparam int LCS_NUM_CH = 2;
	// Index of each channel's flash register within the bank; mask and torch follow
	localparam int LCS_CH_BASE_IDX = 1;
	localparam int LCS_CH_STRIDE = 3;
	// Reset codes, entry 0 is the low battery register
	localparam logic [6:0][5:0] LCS_RST = {6'h04, 6'h28, 6'h28, 6'h04, 6'h28, 6'h28, 6'h10};
	// Writable code bits; upper bits are reserved and read as zero
	localparam logic [6:0][5:0] LCS_MASK = {6'h1f, 6'h3f, 6'h3f, 6'h1f, 6'h3f, 6'h3f, 6'h3f};
	// ----------------------------------------------------------------
	// Current scaling, in units of 0.1 mA
	// ----------------------------------------------------------------
	localparam logic [13:0] LCS_STEP_DMA = 14'h00bb;
	localparam logic [5:0] LCS_FLASH_SAT = 6'h3c;
	localparam logic [4:0] LCS_TORCH_SAT = 5'h10;
	// ----------------------------------------------------------------
	// Mode and pin configuration codes
	// ----------------------------------------------------------------
	localparam logic [2:0] LCS_MODE_STANDBY = 3'h0;
	localparam logic [2:0] LCS_MODE_ASSIST = 3'h2;
	localparam logic [2:0] LCS_MODE_FLASH = 3'h3;
	localparam logic [2:0] LCS_MODE_IND_TO = 3'h4;
	localparam logic [2:0] LCS_MODE_IND_NTO = 3'h5;
	localparam logic [2:0] LCS_MODE_FIX_TORCH = 3'h6;
	localparam logic [1:0] LCS_PIN_HIZ = 2'h0;
	localparam logic [1:0] LCS_PIN_TORCH = 2'h1;
	localparam logic [1:0] LCS_PIN_MASK = 2'h2;
	localparam logic [1:0] LCS_PIN_TORCH_RAW = 2'h3;
	localparam logic [2:0] LCS_LB_OFF = 3'h0;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int LCS_CLK_PERIOD_NS = 10;
	localparam int LCS_DEGLITCH_MS = 10;
	localparam int LCS_DEGLITCH_CYC = LCS_DEGLITCH_MS * 1000000 / LCS_CLK_PERIOD_NS;
	// Target address on the serial link; value is arbitrary
	localparam logic [6:0] LCS_DEV_ADDR = 7'h30;
	typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_PTR, ST_WR, ST_RD, ST_RACK} lcs_state_t;
endpackage
`default_nettype wire

// ==== dv/lcs_regs_monitor.sv ====
// Checker for the LED current register bank outputs
`default_nettype none
module lcs_regs_monitor
	import lcs_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// Serial link
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out_r,
	input wire logic sda_oe_r,
	// Configuration and status
	input wire logic [2:0] output_mode_field,
	input wire logic [1:0] pin_cfg_field,
	input wire logic [2:0] low_batt_threshold_field,
	input wire logic multipurpose_pin_in,
	input wire logic low_batt_detect_in,
	// Current source control
	input wire logic [5:0] ch1_code_r,
	input wire logic [5:0] ch2_code_r,
	input wire logic [13:0] ch1_current_r,
	input wire logic [13:0] ch2_current_r,
	input wire logic mask_applied_r,
	input wire logic low_batt_applied_r
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	wire flash_w = output_mode_field inside {LCS_MODE_FLASH, LCS_MODE_IND_TO, LCS_MODE_IND_NTO};
	wire torch_w = output_mode_field inside {LCS_MODE_ASSIST, LCS_MODE_FIX_TORCH};
	wire off_w = output_mode_field inside {3'h1, 3'h7}
		|| (output_mode_field == LCS_MODE_STANDBY && pin_cfg_field == LCS_PIN_HIZ);
	wire mask_w = pin_cfg_field == LCS_PIN_MASK && multipurpose_pin_in;
	wire lb_w = low_batt_threshold_field != LCS_LB_OFF && low_batt_detect_in;
	function automatic logic [13:0] f_cur(logic [5:0] c, logic [5:0] lim);
		return 14'(c > lim ? lim : c) * LCS_STEP_DMA;
	endfunction
	sequence s_flash; flash_w; endsequence
	sequence s_scl_high2; scl_in ##1 scl_in; endsequence
	property p_flash_cur; s_flash |=> ch1_current_r == f_cur(ch1_code_r, 6'h3c)
		&& ch2_current_r == f_cur(ch2_code_r, 6'h3c); endproperty
	property p_torch_cur; torch_w |=> ch1_current_r == f_cur(ch1_code_r, 6'h10) && ch1_code_r < 6'h20
		&& ch2_current_r == f_cur(ch2_code_r, 6'h10) && ch2_code_r < 6'h20; endproperty
	property p_off; off_w |=> ch1_code_r == 6'h00 && ch2_code_r == 6'h00 && ch1_current_r == 14'h0000
		&& ch2_current_r == 14'h0000; endproperty
	property p_mask; s_flash ##0 mask_w |=> mask_applied_r && !low_batt_applied_r; endproperty
	property p_nomask; pin_cfg_field != LCS_PIN_MASK |=> !mask_applied_r; endproperty
	property p_lb; s_flash ##0 (!mask_w && lb_w) |=> low_batt_applied_r; endproperty
	property p_lb_off; low_batt_threshold_field == LCS_LB_OFF |=> !low_batt_applied_r; endproperty
	property p_flags; !flash_w |=> !mask_applied_r && !low_batt_applied_r; endproperty
	property p_oe_hold; s_scl_high2 |-> !$rose(sda_oe_r) && sda_out_r == 1'b0; endproperty
	a_flash_cur: assert property (p_flash_cur) else $error("flash current mismatch");
	a_torch_cur: assert property (p_torch_cur) else $error("torch current mismatch");
	a_off: assert property (p_off) else $error("idle mode drives current");
	a_mask: assert property (p_mask) else $error("mask code not applied");
	a_nomask: assert property (p_nomask) else $error("mask applied without mask pin");
	a_lb: assert property (p_lb) else $error("low battery code not applied");
	a_lb_off: assert property (p_lb_off) else $error("low battery applied while off");
	a_flags: assert property (p_flags) else $error("flash flags outside flash");
	a_oe_hold: assert property (p_oe_hold) else $error("data driven during clock high");
endmodule // lcs_regs_monitor
bind lcs_regs lcs_regs_monitor lcs_regs_monitor_inst (.clk_sys(clk_sys), .srst(srst),
	.scl_in(scl_in), .sda_in(sda_in), .sda_out_r(sda_out_r), .sda_oe_r(sda_oe_r),
	.output_mode_field(output_mode_field), .pin_cfg_field(pin_cfg_field),
	.low_batt_threshold_field(low_batt_threshold_field), .multipurpose_pin_in(multipurpose_pin_in),
	.low_batt_detect_in(low_batt_detect_in), .ch1_code_r(ch1_code_r), .ch2_code_r(ch2_code_r),
	.ch1_current_r(ch1_current_r), .ch2_current_r(ch2_current_r),
	.mask_applied_r(mask_applied_r), .low_batt_applied_r(low_batt_applied_r));
`default_nettype wire

// ==== dv/lcs_host.sv ====
// Serial host controller model for the register link
`default_nettype none
module lcs_host
	import lcs_pkg::*;
(
	// Clock
	input wire logic clk_sys,
	// Link, data is open drain
	output logic scl_o,
	output logic sda_low_o,
	input wire logic sda_i
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
	begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	// Data changes only while clock is low
	task automatic bit_io(input logic b, output logic r);
		tick(2);
		sda_low_o <= !b;
		tick(3);
		scl_o <= 1'b1;
		tick(4);
		r = sda_i;
		scl_o <= 1'b0;
	endtask
	task automatic byte_io(input logic [8:0] tx, output logic [8:0] rx);
		for (int i = 8; i >= 0; i--)
			bit_io(tx[i], rx[i]);
	endtask
	task automatic start();
		tick(2);
		sda_low_o <= 1'b0;
		tick(3);
		scl_o <= 1'b1;
		tick(4);
		sda_low_o <= 1'b1;
		tick(4);
		scl_o <= 1'b0;
	endtask
	task automatic stop();
		tick(2);
		sda_low_o <= 1'b1;
		tick(3);
		scl_o <= 1'b1;
		tick(4);
		sda_low_o <= 1'b0;
		tick(4);
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d,
		output logic [2:0] nak);
		logic [8:0] r0, r1, r2;
		start();
		byte_io({a, 2'b01}, r0);
		byte_io({p, 1'b1}, r1);
		byte_io({d, 1'b1}, r2);
		stop();
		nak = {r0[0], r1[0], r2[0]};
	endtask
	task automatic rd(input logic [7:0] p, output logic [7:0] d);
		logic [8:0] r;
		start();
		byte_io({LCS_DEV_ADDR, 2'b01}, r);
		byte_io({p, 1'b1}, r);
		start();
		byte_io({LCS_DEV_ADDR, 2'b11}, r);
		byte_io(9'h1ff, r);
		stop();
		d = r[8:1];
	endtask
endmodule // lcs_host
`default_nettype wire

// ==== dv/tb_top.sv ====
// Self-checking bench for the LED current register bank
`default_nettype none
module tb_top
	import lcs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys, srst, scl, host_low, sda_out, sda_oe, pin, lbd, mflag, lflag;
	logic [2:0] mode, thr;
	logic [1:0] cfg;
	logic [5:0] c1, c2;
	logic [13:0] i1, i2;
	logic [7:0] d;
	logic [2:0] nak;
	logic [5:0] rf [7] = '{6'h10, 6'h28, 6'h28, 6'h04, 6'h28, 6'h28, 6'h04};
	int mismatches, checked, cyc;
	wire sda_in = !(host_low | sda_oe);
	lcs_regs #(.DEGLITCH_CYC(8)) lcs_regs_inst (.clk_sys(clk_sys), .srst(srst), .scl_in(scl),
		.sda_in(sda_in), .sda_out_r(sda_out), .sda_oe_r(sda_oe), .output_mode_field(mode),
		.pin_cfg_field(cfg), .low_batt_threshold_field(thr), .multipurpose_pin_in(pin),
		.low_batt_detect_in(lbd), .ch1_code_r(c1), .ch2_code_r(c2), .ch1_current_r(i1),
		.ch2_current_r(i2), .mask_applied_r(mflag), .low_batt_applied_r(lflag));
	lcs_host lcs_host_inst (.clk_sys(clk_sys), .scl_o(scl), .sda_low_o(host_low), .sda_i(sda_in));
	always #5 clk_sys = !clk_sys;
	function automatic logic [13:0] cur(logic [5:0] c, logic [5:0] lim);
		return 14'(c > lim ? lim : c) * 14'h00bb;
	endfunction
	task automatic chk(string n, logic [13:0] e, logic [13:0] s);
		checked++;
		if (s !== e)
		begin
			$display("[ERR] %s expected %h seen %h", n, e, s);
			mismatches++;
		end
	endtask
	task automatic close_out();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Settle past the deglitch window, then compare selected codes
	task automatic settle();
		logic [5:0] e [2];
		int k;
		logic mk, lb;
		repeat (20) @(posedge clk_sys);
		#1;
		k = mode inside {3'h3, 3'h4, 3'h5} ? 1 : (mode inside {3'h2, 3'h6}
			|| (mode == 3'h0 && cfg[0] && pin)) ? 2 : 0;
		mk = k == 1 && cfg == 2'h2 && pin;
		lb = k == 1 && !mk && thr != 3'h0 && lbd;
		for (int c = 0; c < 2; c++)
			e[c] = k == 0 ? 6'h00 : k == 2 ? rf[3 + 3 * c] : mk ? rf[2 + 3 * c] : lb ? rf[0]
				: rf[1 + 3 * c];
		chk("ch1_code", e[0], c1);
		chk("ch2_code", e[1], c2);
		chk("ch1_current", cur(e[0], k == 2 ? 6'h10 : 6'h3c), i1);
		chk("ch2_current", cur(e[1], k == 2 ? 6'h10 : 6'h3c), i2);
		chk("mask_flag", mk, mflag);
		chk("low_batt_flag", lb, lflag);
		chk("sda_out", 1'b0, sda_out);
	endtask
	task automatic apply(logic [2:0] m, logic [1:0] pc, logic p, logic [2:0] t, logic l);
		@(posedge clk_sys);
		mode <= m;
		cfg <= pc;
		pin <= p;
		thr <= t;
		lbd <= l;
		settle();
	endtask
	task automatic put(int i, logic [5:0] v);
		rf[i] = v & ((i == 3 || i == 6) ? 6'h1f : 6'h3f);
		lcs_host_inst.wr(LCS_DEV_ADDR, 8'(5 + i), {2'b00, rf[i]}, nak);
		chk("write_ack", 3'b000, nak);
	endtask
	task automatic get(int i);
		lcs_host_inst.rd(8'(5 + i), d);
		chk("readback", {2'b00, rf[i]}, d);
	endtask
	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 90000)
		begin
			mismatches++;
			close_out();
		end
	end
	initial
	begin
		clk_sys = 0;
		srst = 1;
		{mode, cfg, thr, pin, lbd} = {LCS_MODE_FLASH, 7'h00};
		void'($urandom(32'h1760_c138));
		repeat (10) @(posedge clk_sys);
		srst <= 1'b0;
		settle();
		for (int i = 0; i < 7; i++)
			get(i);
		lcs_host_inst.rd(8'h0c, d);
		chk("unmapped", 8'h00, d);
		lcs_host_inst.wr(7'h31, 8'h06, 8'h00, nak);
		chk("foreign_nak", 3'b111, nak);
		get(1);
		foreach (rf[i])
			put(i, 6'h3e + 6'(i));
		apply(LCS_MODE_FLASH, 2'h0, 1'b0, 3'h0, 1'b0);
		apply(LCS_MODE_ASSIST, 2'h0, 1'b0, 3'h0, 1'b0);
		for (int m = 0; m < 8; m++)
			for (int pc = 0; pc < 4; pc++)
				apply(3'(m), 2'(pc), 1'b1, 3'h1, 1'b1);
		repeat (30)
		begin
			put($urandom_range(6), 6'($urandom));
			get($urandom_range(6));
			apply(3'($urandom), 2'($urandom), 1'($urandom), 3'($urandom), 1'($urandom));
		end
		// Mid-run reset restores every code
		@(posedge clk_sys);
		srst <= 1'b1;
		repeat (3) @(posedge clk_sys);
		#1;
		chk("reset_outputs", 14'h0000, {mflag, lflag, c1, c2});
		chk("reset_current", 14'h0000, i1 | i2);
		@(posedge clk_sys);
		srst <= 1'b0;
		rf = '{6'h10, 6'h28, 6'h28, 6'h04, 6'h28, 6'h28, 6'h04};
		settle();
		for (int i = 0; i < 7; i++)
			get(i);
		close_out();
	end
endmodule // tb_top
`default_nettype wire
